// >>> design/adc_acquisition_sequencer.sv
// Successive-approximation converter sequencer with APB registers and interrupt
`timescale 1ns/100ps
module adc_acquisition_sequencer
  import adc_seq_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rcTick,
  input  wire logic        compIn,
  output logic [9:0]       dacCode,
  output logic             holdSample,
  output logic             irq
);

  logic         rstMeta;
  logic         rstN;
  seq_regs_type seqReg;
  seq_regs_type seqNext;
  logic         tick;
  logic         run;
  logic         setup;
  logic         wrAccess;
  logic         setDone;
  logic         clrDone;
  logic [9:0]   sarKeep;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta <= 1'b0;
      rstN    <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN    <= rstMeta;
    end
  end

  // Bit-period timing runs only outside the sampling state
  assign run = (seqReg.state != ST_SAMPLE);

  adc_tick_gen tickGen (
    .clk    (clk),
    .rstN   (rstN),
    .run    (run),
    .clkSel (seqReg.clkSel),
    .rcTick (rcTick),
    .tick   (tick)
  );

  assign setup    = psel && !penable;
  assign wrAccess = psel && penable && pwrite;

  // Sequencer, APB decode and interrupt in one next-state process
  always_comb begin
    seqNext = seqReg;
    setDone = 1'b0;
    clrDone = 1'b0;
    sarKeep = compIn ? seqReg.sar : (seqReg.sar & ~seqReg.trial);

    unique case (seqReg.state)
      ST_SAMPLE: begin
        if (seqReg.start && seqReg.enable) begin
          if (seqReg.acqSel == ACQ_NONE) begin
            seqNext.state = ST_CONV;
            seqNext.cnt   = 5'h00;
            seqNext.sar   = SAR_MSB;
            seqNext.trial = SAR_MSB;
          end else begin
            seqNext.state = ST_ACQ;
            seqNext.cnt   = acq_periods(seqReg.acqSel);
          end
        end
      end
      ST_ACQ: begin
        if (tick) begin
          if (seqReg.cnt == 5'h01) begin
            seqNext.state = ST_CONV;
            seqNext.cnt   = 5'h00;
            seqNext.sar   = SAR_MSB;
            seqNext.trial = SAR_MSB;
          end else begin
            seqNext.cnt = seqReg.cnt - 5'h01;
          end
        end
      end
      ST_CONV: begin
        if (tick) begin
          if (seqReg.cnt == CONV_LAST) begin
            // Eleventh period transfers the result
            seqNext.result = seqReg.sar;
            seqNext.start  = 1'b0;
            setDone        = 1'b1;
            seqNext.state  = ST_WAIT;
            seqNext.cnt    = 5'h00;
          end else begin
            // Keep or drop the trial bit, then try the next lower one
            seqNext.sar   = sarKeep | (seqReg.trial >> 1);
            seqNext.trial = seqReg.trial >> 1;
            seqNext.cnt   = seqReg.cnt + 5'h01;
          end
        end
      end
      ST_WAIT: begin
        if (tick) begin
          if (seqReg.cnt == POST_WAIT - 5'h01) begin
            seqNext.state = ST_SAMPLE;
          end else begin
            seqNext.cnt = seqReg.cnt + 5'h01;
          end
        end
      end
    endcase

    // Register writes take effect at the access edge
    if (wrAccess) begin
      unique case (paddr)
        OFS_CTRL: begin
          seqNext.enable = pwdata[CTRL_EN_BIT];
          seqNext.start  = pwdata[CTRL_START_BIT] && pwdata[CTRL_EN_BIT];
          // Clearing start mid-flight aborts; result stays as it was
          if (!pwdata[CTRL_START_BIT] &&
              (seqReg.state == ST_ACQ || seqReg.state == ST_CONV)) begin
            seqNext.state  = ST_WAIT;
            seqNext.cnt    = 5'h00;
            seqNext.result = seqReg.result;
          end
          if (!pwdata[CTRL_EN_BIT]) begin
            seqNext.state = ST_SAMPLE;
          end
        end
        OFS_TIMING: begin
          seqNext.clkSel = pwdata[TIM_CLK_LSB +: 3];
          seqNext.acqSel = pwdata[TIM_ACQ_LSB +: 3];
        end
        OFS_IRQ_STAT: begin
          clrDone = pwdata[IRQ_DONE_BIT];
        end
        OFS_IRQ_MASK: begin
          seqNext.doneMask = pwdata[IRQ_DONE_BIT];
        end
        default: begin
        end
      endcase
    end

    // Hardware set wins over a software clear in the same cycle
    seqNext.doneFlag = (seqReg.doneFlag && !clrDone) || setDone;
    seqNext.irq      = seqNext.doneFlag && seqNext.doneMask;
    seqNext.hold     = (seqNext.state == ST_CONV) || (seqNext.state == ST_WAIT);

    // Read data and error are prepared in the setup cycle
    seqNext.ready = 1'b1;
    if (setup) begin
      seqNext.rdata  = RDATA_RST;
      seqNext.slverr = 1'b0;
      unique case (paddr)
        OFS_CTRL: begin
          seqNext.rdata[CTRL_START_BIT] = seqReg.start;
          seqNext.rdata[CTRL_EN_BIT]    = seqReg.enable;
        end
        OFS_TIMING: begin
          seqNext.rdata[TIM_CLK_LSB +: 3] = seqReg.clkSel;
          seqNext.rdata[TIM_ACQ_LSB +: 3] = seqReg.acqSel;
        end
        OFS_RESULT:   seqNext.rdata[9:0]          = seqReg.result;
        OFS_IRQ_STAT: seqNext.rdata[IRQ_DONE_BIT] = seqReg.doneFlag;
        OFS_IRQ_MASK: seqNext.rdata[IRQ_DONE_BIT] = seqReg.doneMask;
        default: begin
          seqNext.slverr = 1'b1;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      seqReg        <= '0;
      seqReg.state  <= ST_SAMPLE;
      seqReg.clkSel <= CLK_SEL_RST;
      seqReg.acqSel <= ACQ_SEL_RST;
      seqReg.result <= RESULT_RST;
      seqReg.rdata  <= RDATA_RST;
    end else begin
      seqReg <= seqNext;
    end
  end

  // Outputs straight from the state register
  assign prdata     = seqReg.rdata;
  assign pready     = seqReg.ready;
  assign pslverr    = seqReg.slverr;
  assign dacCode    = seqReg.sar;
  assign holdSample = seqReg.hold;
  assign irq        = seqReg.irq;

  // Bit periods seen inside a conversion, for checking only
  logic [4:0] convTicks;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      convTicks <= 5'h00;
    end else if (seqReg.state != ST_CONV) begin
      convTicks <= 5'h00;
    end else if (tick) begin
      convTicks <= convTicks + 5'h01;
    end
  end

  a_hold_in_conv: assert property (@(posedge clk) disable iff (!rstN)
    (seqReg.state == ST_CONV) |-> holdSample)
    else $error("hold capacitor connected during conversion");

  a_zero_acq_start: assert property (@(posedge clk) disable iff (!rstN)
    (seqReg.state == ST_SAMPLE && seqReg.start && seqReg.enable &&
     seqReg.acqSel == ACQ_NONE && !wrAccess)
    |=> (seqReg.state == ST_CONV && seqReg.sar == SAR_MSB))
    else $error("zero acquisition start did not convert at once");

  a_acq_load: assert property (@(posedge clk) disable iff (!rstN)
    (seqReg.state == ST_SAMPLE && seqReg.start && seqReg.enable &&
     seqReg.acqSel != ACQ_NONE && !wrAccess)
    |=> (seqReg.state == ST_ACQ && seqReg.cnt == acq_periods($past(seqReg.acqSel))))
    else $error("programmed acquisition length wrong");

  a_acq_then_conv: assert property (@(posedge clk) disable iff (!rstN)
    (seqReg.state == ST_ACQ && tick && seqReg.cnt == 5'h01 && !wrAccess)
    |=> (seqReg.state == ST_CONV && seqReg.start))
    else $error("acquisition did not roll into conversion");

  a_done_effects: assert property (@(posedge clk) disable iff (!rstN)
    (seqReg.state == ST_CONV && tick && seqReg.cnt == CONV_LAST && !wrAccess)
    |=> (!seqReg.start && seqReg.doneFlag && seqReg.state == ST_WAIT &&
         seqReg.result == $past(seqReg.sar)))
    else $error("completion did not clear start, flag done and load result");

  a_start_busy: assert property (@(posedge clk) disable iff (!rstN)
    ((seqReg.state == ST_ACQ || seqReg.state == ST_CONV) && !$past(wrAccess))
    |-> seqReg.start)
    else $error("start bit dropped while busy");

  a_conv_len: assert property (@(posedge clk) disable iff (!rstN)
    (seqReg.state == ST_CONV && tick && seqReg.cnt == CONV_LAST)
    |-> (convTicks == CONV_LAST))
    else $error("conversion length is not eleven bit periods");

  a_wait_two: assert property (@(posedge clk) disable iff (!rstN)
    ($rose(seqReg.state == ST_WAIT)) |-> (seqReg.state != ST_SAMPLE) [*2])
    else $error("acquisition resumed too soon after conversion");

  a_irq_level: assert property (@(posedge clk) disable iff (!rstN)
    (seqReg.doneFlag && seqReg.doneMask) |-> irq)
    else $error("unmasked done flag without interrupt");

  c_zero_acq: cover property (@(posedge clk) disable iff (!rstN)
    (seqReg.state == ST_SAMPLE && seqReg.start) ##1 (seqReg.state == ST_CONV));
  c_prog_acq: cover property (@(posedge clk) disable iff (!rstN)
    (seqReg.state == ST_ACQ) ##1 (seqReg.state == ST_CONV));
  c_abort: cover property (@(posedge clk) disable iff (!rstN)
    (seqReg.state == ST_CONV) ##1 (seqReg.state == ST_WAIT && !seqReg.doneFlag));
  c_irq: cover property (@(posedge clk) disable iff (!rstN) $rose(irq));

endmodule

// >>> design/adc_tick_gen.sv
// Conversion-bit period tick generator from the oscillator or the RC clock
`timescale 1ns/100ps
module adc_tick_gen
  import adc_seq_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstN,
  input  wire logic       run,
  input  wire logic [2:0] clkSel,
  input  wire logic       rcTick,
  output logic            tick
);

  tick_regs_type tickReg;
  tick_regs_type tickNext;
  logic          rcSel;

  assign rcSel = (clkSel[1:0] == CLK_RC_LOW);

  // Divider idles at zero so each run starts a full period
  always_comb begin
    tickNext      = tickReg;
    tickNext.tick = 1'b0;
    if (!run) begin
      tickNext.cnt   = 6'h00;
      tickNext.delay = TCY_CLKS;
    end else if (rcSel) begin
      // Hold the RC clock off one instruction cycle, time to enter sleep
      if (tickReg.delay != 3'h0) begin
        tickNext.delay = tickReg.delay - 3'h1;
      end else begin
        tickNext.tick = rcTick;
      end
    end else if (tickReg.cnt == div_limit(clkSel)) begin
      tickNext.cnt  = 6'h00;
      tickNext.tick = 1'b1;
    end else begin
      tickNext.cnt = tickReg.cnt + 6'h01;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      tickReg <= '0;
    end else begin
      tickReg <= tickNext;
    end
  end

  assign tick = tickReg.tick;

  // Divide by two gives a tick every second cycle
  a_div_two: assert property (@(posedge clk) disable iff (!rstN)
    (run && clkSel == CLK_DIV2 && tick) ##1 (run && clkSel == CLK_DIV2)
    |-> !tick ##1 (tick || !run || clkSel != CLK_DIV2))
    else $error("bit period tick spacing wrong for divide by two");

  // RC clock gives no tick during the first instruction cycle
  a_rc_delay: assert property (@(posedge clk) disable iff (!rstN)
    ($rose(run) && rcSel) |-> !tick [*4])
    else $error("rc clock started before the instruction cycle delay");

endmodule

// >>> inc/adc_seq_pkg.sv
// Shared constants, encodings and carrier types of the acquisition sequencer
package adc_seq_pkg;

  // APB register byte offsets
  localparam logic [31:0] OFS_CTRL      = 32'h0000_0000;
  localparam logic [31:0] OFS_TIMING    = 32'h0000_0004;
  localparam logic [31:0] OFS_RESULT    = 32'h0000_0008;
  localparam logic [31:0] OFS_IRQ_STAT  = 32'h0000_000C;
  localparam logic [31:0] OFS_IRQ_MASK  = 32'h0000_0010;

  // Field positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_EN_BIT    = 1;
  localparam int TIM_CLK_LSB    = 0;
  localparam int TIM_ACQ_LSB    = 3;
  localparam int IRQ_DONE_BIT   = 0;

  // Reset values
  localparam logic [2:0]  CLK_SEL_RST = 3'h0;
  localparam logic [2:0]  ACQ_SEL_RST = 3'h0;
  localparam logic [9:0]  RESULT_RST  = 10'h000;
  localparam logic [31:0] RDATA_RST   = 32'h0000_0000;

  // Conversion clock select encodings
  localparam logic [2:0] CLK_DIV2   = 3'h0;
  localparam logic [1:0] CLK_RC_LOW = 2'h3;

  // Acquisition select value meaning no programmed delay
  localparam logic [2:0] ACQ_NONE = 3'h0;

  // Sequencing counts in conversion-bit periods, and the first SAR trial bit
  localparam logic [4:0] CONV_LAST   = 5'h0A;
  localparam logic [4:0] POST_WAIT   = 5'h02;
  localparam logic [9:0] SAR_MSB     = 10'h200;

  // One instruction cycle is four oscillator periods
  localparam int        TCY_OSC    = 4;
  localparam logic [2:0] TCY_CLKS  = 3'(TCY_OSC);

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_SAMPLE = 4'h1,
    ST_ACQ    = 4'h2,
    ST_CONV   = 4'h4,
    ST_WAIT   = 4'h8
  } seq_state_type;

  // Acquisition periods per select code
  function automatic logic [4:0] acq_periods(input logic [2:0] sel);
    logic [4:0] p;
    p = 5'h00;
    unique case (sel)
      3'h0: p = 5'h00;
      3'h1: p = 5'h02;
      3'h2: p = 5'h04;
      3'h3: p = 5'h06;
      3'h4: p = 5'h08;
      3'h5: p = 5'h0C;
      3'h6: p = 5'h10;
      3'h7: p = 5'h14;
    endcase
    return p;
  endfunction

  // Oscillator periods per bit period, minus one; RC codes unused here
  function automatic logic [5:0] div_limit(input logic [2:0] sel);
    logic [5:0] d;
    d = 6'h01;
    unique case (sel)
      3'h0: d = 6'h01;
      3'h4: d = 6'h03;
      3'h1: d = 6'h07;
      3'h5: d = 6'h0F;
      3'h2: d = 6'h1F;
      3'h6: d = 6'h3F;
      default: d = 6'h01;
    endcase
    return d;
  endfunction

  // State of the bit-period generator
  typedef struct packed {
    logic [5:0] cnt;
    logic [2:0] delay;
    logic       tick;
  } tick_regs_type;

  // State of the sequencer and its register file
  typedef struct packed {
    seq_state_type state;
    logic          enable;
    logic          start;
    logic [2:0]    clkSel;
    logic [2:0]    acqSel;
    logic [4:0]    cnt;
    logic [9:0]    sar;
    logic [9:0]    trial;
    logic [9:0]    result;
    logic          doneFlag;
    logic          doneMask;
    logic          irq;
    logic          hold;
    logic [31:0]   rdata;
    logic          slverr;
    logic          ready;
  } seq_regs_type;

endpackage

// >>> sim/adc_acquisition_sequencer_tb_top.sv
// Self-checking bench for the acquisition sequencer over its APB port
`timescale 1ns/100ps
module adc_acquisition_sequencer_tb_top;
  import adc_seq_pkg::*;

  logic        clk;
  logic        reset_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rcTick;
  logic        compIn;
  logic [9:0]  dacCode;
  logic        holdSample;
  logic        irq;
  logic [9:0]  tgt;
  logic [2:0]  rcCnt;
  int          error_cnt;
  int          n_checks;

  adc_acquisition_sequencer DUT (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rcTick(rcTick), .compIn(compIn), .dacCode(dacCode), .holdSample(holdSample), .irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Comparator model: keeps the trial bit while the held input is at or above it
  // It settles within one clock, so every divider is long enough here
  always @(posedge clk) begin
    if (!reset_n) begin
      compIn <= 1'b0;
    end else begin
      compIn <= (tgt >= dacCode);
    end
  end

  // Internal RC oscillator stand-in: one pulse every five clocks
  // It runs free, as it would with the device asleep for the conversion
  always @(posedge clk) begin
    if (!reset_n) begin
      rcCnt  <= 3'h0;
      rcTick <= 1'b0;
    end else begin
      rcCnt  <= (rcCnt == 3'h4) ? 3'h0 : rcCnt + 3'h1;
      rcTick <= (rcCnt == 3'h4);
    end
  end

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Range compare for measured cycle counts
  task automatic near(input int g, input int lo, input int hi);
    n_checks++;
    if (g < lo || g > hi) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, lo);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
  endtask

  // Start one conversion, count cycles to hold and the length of the hold
  task automatic conv(input logic [2:0] cs, input logic [2:0] acq, input logic [9:0] t,
                      output int aC, output int hC);
    tgt <= t;
    wr(OFS_TIMING, {26'h0, acq, cs});
    // New input level is sampled for a while before the start bit is set
    repeat (2) @(posedge clk);
    wr(OFS_CTRL, 32'h3);
    aC = 0;
    while (holdSample !== 1'b1 && aC < 3000) begin
      @(posedge clk);
      aC++;
    end
    hC = 0;
    while (holdSample === 1'b1 && hC < 3000) begin
      @(posedge clk);
      hC++;
    end
  endtask

  initial begin
    #200us;
    error_cnt++;
    print_verdict();
  end

  initial begin
    int a0;
    int aC;
    int hC;
    int p;
    logic [31:0] r;
    logic        e;
    logic [9:0]  t;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    tgt = 10'h000;
    error_cnt = 0;
    n_checks = 0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset state of every register, then an unmapped place
    rd(OFS_CTRL, 32'h0);
    rd(OFS_TIMING, 32'h0);
    rd(OFS_RESULT, 32'h0);
    rd(OFS_IRQ_STAT, 32'h0);
    rd(OFS_IRQ_MASK, 32'h0);
    apb(1'b0, 32'h0000_0014, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    // Every acquisition code with the fastest divider, interrupt masked
    for (int i = 0; i < 8; i++) begin
      t = (i == 0) ? 10'h000 : 10'(i * 146);
      conv(3'h0, 3'(i), t, aC, hC);
      if (i == 0) a0 = aC;
      p = (i == 0) ? 0 : (i < 5) ? 2 * i : 4 * i - 8;
      near(aC - a0, 2 * p - 1, 2 * p + 1);
      near(hC, 25, 27);
      rd(OFS_RESULT, {22'h0, t});
      rd(OFS_CTRL, 32'h2);
      rd(OFS_IRQ_STAT, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wr(OFS_IRQ_STAT, 32'h1);
      rd(OFS_IRQ_STAT, 32'h0);
    end
    // Every clock select code with the interrupt unmasked
    wr(OFS_IRQ_MASK, 32'h1);
    for (int c = 0; c < 8; c++) begin
      t = 10'h2AA ^ 10'(c * 33);
      p = (c[1:0] == 2'h3) ? 5 : 2 << (c[1:0] * 2 + c[2]);
      conv(3'(c), 3'h0, t, aC, hC);
      if (c[1:0] == 2'h3) near(hC, 64, 75);
      else near(hC, 13 * p - 1, 13 * p + 1);
      rd(OFS_RESULT, {22'h0, t});
      chk({31'h0, irq}, 32'h1);
      wr(OFS_IRQ_STAT, 32'h1);
      // Interrupt is registered from the next flag value, so it drops at the clearing edge; check it one edge later
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
    end
    // Start bit stays set through acquisition and conversion, then an abort
    tgt <= 10'h155;
    wr(OFS_TIMING, {26'h0, 3'h7, 3'h0});
    wr(OFS_CTRL, 32'h3);
    rd(OFS_CTRL, 32'h3);
    chk({31'h0, holdSample}, 32'h0);
    aC = 0;
    while (holdSample !== 1'b1 && aC < 100) begin
      @(posedge clk);
      aC++;
    end
    rd(OFS_CTRL, 32'h3);
    wr(OFS_CTRL, 32'h2);
    hC = 0;
    while (holdSample === 1'b1 && hC < 100) begin
      @(posedge clk);
      hC++;
    end
    near(hC, 3, 6);
    rd(OFS_IRQ_STAT, 32'h0);
    rd(OFS_RESULT, {22'h0, 10'h2AA ^ 10'(7 * 33)});
    chk({31'h0, irq}, 32'h0);
    // Start with enable low is refused, and an unmapped write flags an error
    wr(OFS_CTRL, 32'h1);
    rd(OFS_CTRL, 32'h0);
    chk({31'h0, holdSample}, 32'h0);
    apb(1'b1, 32'h0000_0014, 32'h1, r, e);
    chk({31'h0, e}, 32'h1);
    print_verdict();
  end
endmodule
